// [rtl/spr_pkg.sv]
`default_nettype none
package spr_pkg;
	typedef enum logic [1:0] {
		MODE_POR = 2'b00,
		MODE_RUN = 2'b01,
		MODE_HALT = 2'b10,
		MODE_STOP = 2'b11
	} spr_mode_e;
	typedef struct packed {
		spr_mode_e mode;
		logic [23:0] por_cnt;
		logic cmp;
		logic p4_pp;
		logic p5_pp;
		logic presc;
		logic [2:0] src;
		logic delay;
		logic pol;
		logic warm;
		logic [1:0] div;
		logic dsp_run;
		logic dsp_rst;
		logic int2;
		logic irq3;
		logic [1:0] wm_sel;
		logic wm_halt;
		logic wm_stop;
		logic wm_xtal;
		logic wd_en;
		logic [23:0] wd_cnt;
		logic [6:0] win_cnt;
		logic [23:0] hs_cnt;
		logic hs_flag;
		logic [6:0] div_cnt;
		logic [6:0] tmr_cnt;
		logic cpu_tick;
		logic tmr_tick;
		logic cpu_rst;
		logic osc_en;
		logic [15:0] start;
		logic ack;
		logic [7:0] dat;
	} spr_state_s;
endpackage
`default_nettype wire

// [rtl/spr_regs.svh]
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH
// =====================================================
// register indices (byte address = 4 * index)
`define SPR_IDX_PCFG 4'h0
`define SPR_IDX_PDRV 4'h6
`define SPR_IDX_STOP_REC 4'hB
`define SPR_IDX_COPROC 4'hC
`define SPR_IDX_WDOG_MODE 4'hD
`define SPR_IDX_HALF_SEC 4'hE
// =====================================================
// field positions
`define SPR_PCFG_CMP 0
`define SPR_PDRV_P4 0
`define SPR_PDRV_P5 4
`define SPR_SR_PRESC 0
`define SPR_SR_SRC 4:2
`define SPR_SR_DELAY 5
`define SPR_SR_POL 6
`define SPR_SR_WARM 7
`define SPR_CP_DIV 7:6
`define SPR_CP_DSPRST 5
`define SPR_CP_RUN 4
`define SPR_CP_INT2 1
`define SPR_CP_IRQ3 0
`define SPR_WM_SEL 1:0
`define SPR_WM_HALT 2
`define SPR_WM_STOP 3
`define SPR_WM_XTAL 4
`define SPR_HS_FLAG 0
// =====================================================
// reset values
`define SPR_RST_PP 1'b1
`define SPR_RST_DELAY 1'b1
`define SPR_RST_DSP_RUN 1'b1
`define SPR_RST_WM_HALT 1'b1
`define SPR_RST_WM_STOP 1'b1
`define SPR_RESTART_ADDR 16'h000C
// =====================================================
// timing
`define SPR_CLK_HZ 40000000
`define SPR_POR_TIME_US 5000
`define SPR_WD_RC_MS0 5
`define SPR_WD_RC_MS1 15
`define SPR_WD_RC_MS2 25
`define SPR_WD_RC_MS3 100
`define SPR_WD_XT0 256
`define SPR_WD_XT1 512
`define SPR_WD_XT2 1024
`define SPR_WD_XT3 4096
`define SPR_WM_WINDOW 64
`define SPR_RTC_HZ 32768
`endif

// [rtl/spr_sys_ctrl.sv]
// Behaviour
// - pcfg bit 0 routes both comparator outputs to port 3 pins 4 and 5.
// - drive register bits 0/4 pick open-drain or push-pull for ports 4/5; reset 1.
// - reset one-shot on RC ticks, fired by power good, slow recovery, watchdog.
// - reset delay is nominally 5 ms before execution.
// - halt stops cpu clock only; any interrupt resumes.
// - stop kills clock and oscillator; a reset or the chosen wake source ends it, restart at 000CH.
// - stop-recovery register bits 0-6 write-only, bit 7 read-only.
// - stop-recovery bit 0 adds divide-by-16 to cpu and timer clocks.
// - stop-recovery bits 4-2 choose the wake source.
// - stop-recovery bit 5 keeps the reset delay after wake; 0 wakes fast.
// - stop-recovery bit 6 sets wake level polarity; resets to low.
// - warm flag set on entering stop, cleared by power-on or watchdog reset.
// - coprocessor bits 7-6 divide oscillator by 8, 4 or 2; reset 00.
// - writing 1 to coprocessor bit 5 resets the dsp; reads give 0.
// - coprocessor bit 4 gates dsp clock; resumes on 1; reset 1.
// - coprocessor bit 0 shows host interrupt three; dsp sets, write 1 clears.
// - coprocessor bit 1 shows dsp interrupt two; write 1 raises it.
// - watchdog enabled by first kick, restarted by later kicks, resets at end.
// - watchdog mode register open only for 64 cpu clocks after reset delay.
// - half-second flag set from 32.768 kHz ticks in every mode; wakes stop.
// - watchdog mode bits 1-0 choose the time-out per clock source.
// - watchdog mode bits 2/3 keep the watchdog running in halt/stop; a crystal-clocked watchdog here gets no ticks in stop.
// - watchdog mode bit 4 picks crystal ticks over rc ticks.
//
// Our own choice: register access over Wishbone.
`default_nettype none
`include "spr_regs.svh"
module spr_sys_ctrl
	import spr_pkg::*;
#(
	parameter int RC_KHZ = 1000,
	parameter int POR_TICKS = (`SPR_POR_TIME_US * RC_KHZ + 999) / 1000,
	parameter int WD_RC0 = `SPR_WD_RC_MS0 * RC_KHZ,
	parameter int WD_RC1 = `SPR_WD_RC_MS1 * RC_KHZ,
	parameter int WD_RC2 = `SPR_WD_RC_MS2 * RC_KHZ,
	parameter int WD_RC3 = `SPR_WD_RC_MS3 * RC_KHZ,
	parameter int HS_TICKS = `SPR_RTC_HZ / 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// core events
	input wire logic power_good_i,
	input wire logic ext_reset_i,
	input wire logic halt_req_i,
	input wire logic stop_req_i,
	input wire logic wdog_kick_i,
	input wire logic cpu_int_i,
	// clock source ticks
	input wire logic rc_tick_i,
	input wire logic xtal_tick_i,
	input wire logic rtc_tick_i,
	// wake pins
	input wire logic [2:0] wake_p3_i,
	input wire logic [7:0] wake_p2_i,
	// dsp side
	input wire logic dsp_irq3_set_i,
	input wire logic coproc_interrupt_two_clr_i,
	// core control
	output logic cpu_rst_o,
	output logic cpu_tick_o,
	output logic tmr_tick_o,
	output logic osc_en_o,
	output logic [15:0] start_addr_o,
	output logic cmp_route_o,
	output logic p4_push_pull_o,
	output logic p5_push_pull_o,
	output logic dsp_rst_o,
	output logic dsp_clk_en_o,
	output logic coproc_interrupt_two_o,
	output logic host_interrupt_three_o
);
	// =====================================================
	// elaboration checks
	if (POR_TICKS < 1 || POR_TICKS > 24'hFFFFFF || WD_RC3 > 24'hFFFFFF || WD_RC0 < 1) begin : g_bad_cnt
		$error("spr_sys_ctrl: counts do not fit 24 bits");
	end
	if (HS_TICKS < 1 || HS_TICKS > 24'hFFFFFF) begin : g_bad_hs
		$error("spr_sys_ctrl: half-second count out of range");
	end

	// =====================================================
	// functions
	function automatic logic [6:0] spr_per(input logic [1:0] dv, input logic p16);
		logic [6:0] b;
		b = dv[1] ? 7'h02 : (dv[0] ? 7'h04 : 7'h08);
		return p16 ? 7'((b << 4) - 7'h01) : 7'(b - 7'h01);
	endfunction

	function automatic logic [23:0] spr_wd_lim(input logic [1:0] s, input logic xt);
		logic [23:0] r;
		case (s)
			2'b00: r = xt ? 24'(`SPR_WD_XT0) : 24'(WD_RC0);
			2'b01: r = xt ? 24'(`SPR_WD_XT1) : 24'(WD_RC1);
			2'b10: r = xt ? 24'(`SPR_WD_XT2) : 24'(WD_RC2);
			default: r = xt ? 24'(`SPR_WD_XT3) : 24'(WD_RC3);
		endcase
		return r;
	endfunction

	spr_state_s q, d;
	logic wr, rd_ok, win_open, wd_tick, wd_run, wd_fire, hs_evt, lvl, wake, any_rst;
	logic [3:0] idx;
	logic [7:0] wb;

	assign idx = adr_i[5:2];
	assign wb = dat_i[7:0];
	assign wr = cyc_i && stb_i && we_i && !q.ack && sel_i[0];
	assign win_open = q.win_cnt < 7'(`SPR_WM_WINDOW);

	// =====================================================
	// next state
	always_comb begin
		d = q;
		d.ack = cyc_i && stb_i && !q.ack;
		d.dsp_rst = 1'b0;
		d.cpu_tick = 1'b0;
		d.tmr_tick = 1'b0;
		rd_ok = 1'b1;
		// half-second timer runs in every mode
		hs_evt = 1'b0;
		if (rtc_tick_i) begin
			if (q.hs_cnt >= 24'(HS_TICKS - 1)) begin
				d.hs_cnt = 24'h000000;
				hs_evt = 1'b1;
			end else begin
				d.hs_cnt = q.hs_cnt + 24'h000001;
			end
		end
		// watchdog: crystal is dead in stop, so a crystal-clocked watchdog gets no ticks there
		wd_tick = q.wm_xtal ? (xtal_tick_i && q.mode != MODE_STOP) : rc_tick_i;
		wd_run = q.wd_en && (q.mode == MODE_RUN || (q.mode == MODE_HALT && q.wm_halt)
			|| (q.mode == MODE_STOP && q.wm_stop));
		wd_fire = 1'b0;
		if (wdog_kick_i && q.mode == MODE_RUN) begin
			d.wd_en = 1'b1;
			d.wd_cnt = 24'h000000;
		end else if (wd_run && wd_tick) begin
			if (q.wd_cnt >= spr_wd_lim(q.wm_sel, q.wm_xtal) - 24'h000001) begin
				wd_fire = 1'b1;
			end else begin
				d.wd_cnt = q.wd_cnt + 24'h000001;
			end
		end
		// wake source level, polarity applied to pins
		case (q.src)
			3'b010: lvl = wake_p3_i[0];
			3'b011: lvl = wake_p3_i[1];
			3'b100: lvl = wake_p3_i[2];
			3'b110: lvl = ~|wake_p2_i[3:0];
			3'b111: lvl = ~|wake_p2_i;
			default: lvl = ~q.pol;
		endcase
		wake = (q.src == 3'b101) ? hs_evt : (lvl == q.pol);
		// clock dividers; cpu clock stops outside run
		if (q.div_cnt >= spr_per(q.div, q.presc)) begin
			d.div_cnt = 7'h00;
			d.cpu_tick = q.mode == MODE_RUN;
		end else begin
			d.div_cnt = q.div_cnt + 7'h01;
		end
		if (q.tmr_cnt >= spr_per(2'b10, q.presc)) begin
			d.tmr_cnt = 7'h00;
			d.tmr_tick = q.mode == MODE_RUN || q.mode == MODE_HALT;
		end else begin
			d.tmr_cnt = q.tmr_cnt + 7'h01;
		end
		if (q.mode == MODE_RUN && q.cpu_tick && win_open) begin
			d.win_cnt = q.win_cnt + 7'h01;
		end
		// modes
		any_rst = !power_good_i || ext_reset_i || wd_fire;
		case (q.mode)
			MODE_POR: begin
				if (rc_tick_i) begin
					if (q.por_cnt >= 24'(POR_TICKS - 1)) begin
						d.mode = MODE_RUN;
						d.win_cnt = 7'h00;
					end else begin
						d.por_cnt = q.por_cnt + 24'h000001;
					end
				end
			end
			MODE_RUN: begin
				// entry assumes the pipeline was flushed first
				if (stop_req_i) begin
					d.mode = MODE_STOP;
					d.warm = 1'b1;
				end else if (halt_req_i) begin
					d.mode = MODE_HALT;
				end
			end
			MODE_HALT: begin
				if (cpu_int_i) begin
					d.mode = MODE_RUN;
				end
			end
			MODE_STOP: begin
				if (wake && q.src != 3'b000 && q.src != 3'b001) begin
					d.mode = q.delay ? MODE_POR : MODE_RUN;
					d.por_cnt = 24'h000000;
					d.start = `SPR_RESTART_ADDR;
				end
			end
			default: d.mode = MODE_POR;
		endcase
		if (any_rst) begin
			d.mode = MODE_POR;
			d.por_cnt = 24'h000000;
			d.start = `SPR_RESTART_ADDR;
		end
		if (!power_good_i || wd_fire) begin
			d.warm = 1'b0;
			d.wd_en = 1'b0;
			d.wd_cnt = 24'h000000;
		end
		// coprocessor interrupts, set wins over clear
		if (wr && idx == `SPR_IDX_COPROC && wb[`SPR_CP_IRQ3]) begin
			d.irq3 = 1'b0;
		end
		if (dsp_irq3_set_i) begin
			d.irq3 = 1'b1;
		end
		if (coproc_interrupt_two_clr_i) begin
			d.int2 = 1'b0;
		end
		if (wr && idx == `SPR_IDX_COPROC && wb[`SPR_CP_INT2]) begin
			d.int2 = 1'b1;
		end
		if (hs_evt) begin
			d.hs_flag = 1'b1;
		end else if (wr && idx == `SPR_IDX_HALF_SEC && !wb[`SPR_HS_FLAG]) begin
			d.hs_flag = 1'b0;
		end
		// register writes
		if (wr) begin
			if (idx == `SPR_IDX_PCFG) begin
				d.cmp = wb[`SPR_PCFG_CMP];
			end else if (idx == `SPR_IDX_PDRV) begin
				d.p4_pp = wb[`SPR_PDRV_P4];
				d.p5_pp = wb[`SPR_PDRV_P5];
			end else if (idx == `SPR_IDX_STOP_REC) begin
				d.presc = wb[`SPR_SR_PRESC];
				d.src = wb[`SPR_SR_SRC];
				d.delay = wb[`SPR_SR_DELAY];
				d.pol = wb[`SPR_SR_POL];
			end else if (idx == `SPR_IDX_COPROC) begin
				d.div = wb[`SPR_CP_DIV];
				d.dsp_run = wb[`SPR_CP_RUN];
				if (wb[`SPR_CP_DSPRST]) begin
					d.dsp_rst = 1'b1;
					d.dsp_run = 1'b1;
				end
			end else if (idx == `SPR_IDX_WDOG_MODE) begin
				if (win_open) begin
					d.wm_sel = wb[`SPR_WM_SEL];
					d.wm_halt = wb[`SPR_WM_HALT];
					d.wm_stop = wb[`SPR_WM_STOP];
					d.wm_xtal = wb[`SPR_WM_XTAL];
				end
			end
		end
		// read mux
		d.dat = 8'h00;
		if (idx == `SPR_IDX_PCFG) begin
			d.dat[`SPR_PCFG_CMP] = q.cmp;
		end else if (idx == `SPR_IDX_PDRV) begin
			d.dat[`SPR_PDRV_P4] = q.p4_pp;
			d.dat[`SPR_PDRV_P5] = q.p5_pp;
		end else if (idx == `SPR_IDX_STOP_REC) begin
			d.dat[`SPR_SR_WARM] = q.warm;
		end else if (idx == `SPR_IDX_COPROC) begin
			d.dat[`SPR_CP_DIV] = q.div;
			d.dat[`SPR_CP_RUN] = q.dsp_run;
			d.dat[`SPR_CP_INT2] = q.int2;
			d.dat[`SPR_CP_IRQ3] = q.irq3;
		end else if (idx == `SPR_IDX_WDOG_MODE) begin
			if (win_open) begin
				d.dat[`SPR_WM_SEL] = q.wm_sel;
				d.dat[`SPR_WM_HALT] = q.wm_halt;
				d.dat[`SPR_WM_STOP] = q.wm_stop;
				d.dat[`SPR_WM_XTAL] = q.wm_xtal;
			end
		end else if (idx == `SPR_IDX_HALF_SEC) begin
			d.dat[`SPR_HS_FLAG] = q.hs_flag;
		end else begin
			rd_ok = 1'b0;
		end
		if (!rd_ok) begin
			d.dat = 8'h00;
		end
		d.cpu_rst = d.mode == MODE_POR;
		d.osc_en = d.mode != MODE_STOP;
	end

	// =====================================================
	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.mode <= MODE_POR;
			q.p4_pp <= `SPR_RST_PP;
			q.p5_pp <= `SPR_RST_PP;
			q.delay <= `SPR_RST_DELAY;
			q.dsp_run <= `SPR_RST_DSP_RUN;
			q.wm_halt <= `SPR_RST_WM_HALT;
			q.wm_stop <= `SPR_RST_WM_STOP;
			q.cpu_rst <= 1'b1;
			q.osc_en <= 1'b1;
			q.start <= `SPR_RESTART_ADDR;
			q.win_cnt <= 7'(`SPR_WM_WINDOW);
		end else begin
			q <= d;
		end
	end

	assign dat_o = {24'h000000, q.dat};
	assign ack_o = q.ack;
	assign cpu_rst_o = q.cpu_rst;
	assign cpu_tick_o = q.cpu_tick;
	assign tmr_tick_o = q.tmr_tick;
	assign osc_en_o = q.osc_en;
	assign start_addr_o = q.start;
	assign cmp_route_o = q.cmp;
	assign p4_push_pull_o = q.p4_pp;
	assign p5_push_pull_o = q.p5_pp;
	assign dsp_rst_o = q.dsp_rst;
	assign dsp_clk_en_o = q.dsp_run;
	assign coproc_interrupt_two_o = q.int2;
	assign host_interrupt_three_o = q.irq3;

	// =====================================================
	// assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_cmp;
		wr && idx == `SPR_IDX_PCFG |=> cmp_route_o == $past(dat_i[0]);
	endproperty
	a_cmp: assert property (p_cmp) else $error("comparator route not taken");

	property p_drive;
		wr && idx == `SPR_IDX_PDRV |=> p4_push_pull_o == $past(dat_i[0]) && p5_push_pull_o == $past(dat_i[4]);
	endproperty
	a_drive: assert property (p_drive) else $error("drive mode wrong");

	property p_halt_noclk;
		q.mode != MODE_RUN |=> !cpu_tick_o;
	endproperty
	a_halt_noclk: assert property (p_halt_noclk) else $error("cpu tick outside run");

	property p_stop_osc;
		q.mode == MODE_STOP && $past(q.mode) == MODE_STOP |-> !osc_en_o;
	endproperty
	a_stop_osc: assert property (p_stop_osc) else $error("oscillator on in stop");

	property p_warm;
		q.mode == MODE_RUN && stop_req_i && !any_rst |=> q.warm && q.mode == MODE_STOP;
	endproperty
	a_warm: assert property (p_warm) else $error("warm flag not set on stop");

	property p_fast;
		q.mode == MODE_STOP && wake && q.src[2:1] != 2'b00 && !q.delay && !any_rst |=> q.mode == MODE_RUN ##0 !cpu_rst_o;
	endproperty
	a_fast: assert property (p_fast) else $error("fast wake missed");

	property p_irq3;
		dsp_irq3_set_i |=> host_interrupt_three_o;
	endproperty
	a_irq3: assert property (p_irq3) else $error("irq3 set lost");

	property p_window;
		wr && idx == `SPR_IDX_WDOG_MODE && !win_open |=> $stable({q.wm_sel, q.wm_halt, q.wm_stop, q.wm_xtal});
	endproperty
	a_window: assert property (p_window) else $error("late watchdog mode write taken");

	property p_hs_clr;
		wr && idx == `SPR_IDX_HALF_SEC && !dat_i[0] && !hs_evt |=> !q.hs_flag;
	endproperty
	a_hs_clr: assert property (p_hs_clr) else $error("half-second clear failed");
endmodule
`default_nettype wire

// [verif/spr_dsp_model.sv]
`default_nettype none
module spr_dsp_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// commands from the bench
	input wire logic raise_i,
	input wire logic ack_i,
	// device side
	input wire logic dsp_rst_i,
	input wire logic int2_i,
	output logic irq3_set_o,
	output logic int2_clr_o,
	output logic [7:0] rst_cnt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================================
	// dsp core behaviour
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq3_set_o <= 1'b0;
			int2_clr_o <= 1'b0;
			rst_cnt_o <= 8'h00;
		end else begin
			// one-cycle write of its control bit 9
			irq3_set_o <= raise_i;
			// services only a pending interrupt, never clears blindly
			int2_clr_o <= ack_i & int2_i;
			rst_cnt_o <= rst_cnt_o + {7'h00, dsp_rst_i};
		end
	end
endmodule
`default_nettype wire

// [verif/tb.sv]
`default_nettype none
module tb import spr_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================================
	// signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [31:0] wdat = 32'h0;
	logic [6:0] ev = 7'h00;
	logic rc_tick = 1'b0;
	logic rtc_tick = 1'b0;
	logic xtal_tick = 1'b0;
	logic pg = 1'b1;
	logic [3:0] cc = 4'h0;
	logic [2:0] p3 = 3'h0;
	logic [7:0] p2 = 8'hFF;
	logic [31:0] dat_o;
	logic [31:0] q;
	logic ack_o, cpu_rst_o, cpu_tick_o, tmr_tick_o, osc_en_o, cmp_o, p4_o, p5_o;
	logic dsp_rst_o, dsp_clk_en_o, int2_o, host3_o, irq3_set, int2_clr;
	logic [15:0] start_o;
	logic [7:0] rst_cnt;
	int err_count = 0;
	int compares = 0;
	int n;
	int s;
	always #12.5 clk = ~clk;
	// rc tick every 4 cycles, 32.768 kHz tick every 8, crystal tick every 2
	always @(posedge clk) begin
		cc <= cc + 4'h1;
		xtal_tick <= cc[0];
		rc_tick <= (cc[1:0] == 2'h3);
		rtc_tick <= (cc[2:0] == 3'h7);
	end
	// =====================================================
	// design and far side
	spr_sys_ctrl #(.RC_KHZ(1), .HS_TICKS(4)) u_spr_sys_ctrl (
		.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1),
		.dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .power_good_i(pg), .ext_reset_i(ev[6]),
		.halt_req_i(ev[0]), .stop_req_i(ev[1]), .wdog_kick_i(ev[2]), .cpu_int_i(ev[3]),
		.rc_tick_i(rc_tick), .xtal_tick_i(xtal_tick), .rtc_tick_i(rtc_tick), .wake_p3_i(p3), .wake_p2_i(p2),
		.dsp_irq3_set_i(irq3_set), .coproc_interrupt_two_clr_i(int2_clr), .cpu_rst_o(cpu_rst_o),
		.cpu_tick_o(cpu_tick_o), .tmr_tick_o(tmr_tick_o), .osc_en_o(osc_en_o), .start_addr_o(start_o),
		.cmp_route_o(cmp_o), .p4_push_pull_o(p4_o), .p5_push_pull_o(p5_o), .dsp_rst_o(dsp_rst_o),
		.dsp_clk_en_o(dsp_clk_en_o), .coproc_interrupt_two_o(int2_o), .host_interrupt_three_o(host3_o)
	);
	spr_dsp_model u_spr_dsp_model (
		.clk_i(clk), .rst_i(rst), .raise_i(ev[4]), .ack_i(ev[5]), .dsp_rst_i(dsp_rst_o),
		.int2_i(int2_o), .irq3_set_o(irq3_set), .int2_clr_o(int2_clr), .rst_cnt_o(rst_cnt)
	);
	// =====================================================
	// tasks
	task automatic wrap_up;
		if (err_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// classic cycle; request held until ack is seen high at a rising edge, data taken and released there
	task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {26'h0, idx, 2'h0};
		wdat <= {24'h0, d};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		if (ack_o !== 1'b1) chk(32'h0, 32'h1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(q, {24'h0, exp});
	endtask
	task automatic pulse(input int b);
		@(posedge clk);
		ev[b] <= 1'b1;
		@(posedge clk);
		ev[b] <= 1'b0;
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return cpu_rst_o;
			1: return osc_en_o;
			2: return cpu_tick_o;
			default: return tmr_tick_o;
		endcase
	endfunction
	task automatic await(input int k, input logic v, input int lim);
		int m;
		m = 0;
		do begin
			@(negedge clk);
			m++;
		end while (sig(k) !== v && m < lim);
		chk(sig(k), v);
	endtask
	// the interval just after a divider change may be odd, so the second one counts
	task automatic period(input int k, input int exp);
		int m;
		await(k, 1'b1, 300);
		repeat (2) begin
			m = 0;
			do begin
				@(negedge clk);
				m++;
			end while (sig(k) !== 1'b1 && m < 300);
		end
		chk(m, exp);
	endtask
	task automatic count(input int k, input int cycles, input int exp);
		int m;
		m = 0;
		repeat (cycles) begin
			@(negedge clk);
			m += sig(k);
		end
		chk(m, exp);
	endtask
	// =====================================================
	// tests
	initial begin
		#(25ns * 20000);
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		chk(cpu_rst_o, 1'b1);
		await(0, 1'b0, 200);
		rd(4'hD, 8'h0C);
		wr(4'hD, 8'h0D);
		rd(4'hD, 8'h0D);
		rd(4'h6, 8'h11);
		rd(4'hC, 8'h10);
		rd(4'hB, 8'h00);
		rd(4'h3, 8'h00);
		chk({p4_o, p5_o, dsp_clk_en_o, cmp_o}, 4'hE);
		wr(4'h0, 8'h01);
		chk(cmp_o, 1'b1);
		wr(4'h0, 8'h00);
		chk(cmp_o, 1'b0);
		wr(4'h6, 8'h01);
		chk({p4_o, p5_o}, 2'b10);
		wr(4'h6, 8'h10);
		chk({p4_o, p5_o}, 2'b01);
		repeat (600) @(posedge clk);
		rd(4'hD, 8'h00);
		period(2, 8);
		wr(4'hC, 8'h50);
		period(2, 4);
		wr(4'hC, 8'h90);
		period(2, 2);
		period(3, 2);
		wr(4'hB, 8'h21);
		period(2, 32);
		period(3, 32);
		wr(4'hB, 8'h20);
		wr(4'hC, 8'h30);
		repeat (3) @(posedge clk);
		chk(rst_cnt, 8'h01);
		rd(4'hC, 8'h10);
		wr(4'hC, 8'h12);
		chk(int2_o, 1'b1);
		pulse(5);
		repeat (3) @(posedge clk);
		chk(int2_o, 1'b0);
		pulse(4);
		repeat (3) @(posedge clk);
		rd(4'hC, 8'h11);
		wr(4'hC, 8'h11);
		chk(host3_o, 1'b0);
		wr(4'hC, 8'h00);
		chk(dsp_clk_en_o, 1'b0);
		wr(4'hC, 8'h10);
		chk(dsp_clk_en_o, 1'b1);
		pulse(0); // halt request
		count(2, 64, 0);
		count(3, 64, 32);
		pulse(3);
		await(2, 1'b1, 50);
		wr(4'hE, 8'h00);
		n = 0;
		do begin
			bus(1'b0, 4'hE, 8'h00);
			n++;
		end while (q[0] !== 1'b1 && n < 40);
		chk(q, 32'h1);
		wr(4'hE, 8'h00);
		rd(4'hE, 8'h00);
		for (s = 2; s < 8; s++) begin
			wr(4'hB, {3'b010, s[2:0], 2'b00});
			pulse(1); // stop request
			await(1, 1'b0, 5);
			if (s != 5) begin
				repeat (20) @(posedge clk);
				chk(osc_en_o, 1'b0);
			end
			// wake level held only until the oscillator is back on, plus one cycle
			@(posedge clk);
			if (s < 5) p3[s - 2] <= 1'b1;
			if (s == 6) p2 <= 8'hF0;
			if (s == 7) p2 <= 8'h00;
			await(1, 1'b1, 80);
			chk(cpu_rst_o, 1'b0);
			chk(start_o, 16'h000C);
			@(posedge clk);
			p3 <= 3'h0;
			p2 <= 8'hFF;
		end
		rd(4'hB, 8'h80);
		wr(4'hB, 8'h44);
		pulse(1);
		p3 <= 3'h7;
		p2 <= 8'h00;
		repeat (80) @(posedge clk);
		chk(osc_en_o, 1'b0);
		pulse(6);
		await(0, 1'b0, 200);
		rd(4'hB, 8'h80);
		wr(4'hB, 8'h28);
		pulse(1);
		await(1, 1'b0, 5);
		@(posedge clk);
		p3 <= 3'h6;
		await(0, 1'b1, 60);
		await(0, 1'b0, 200);
		pulse(2);
		repeat (10) begin
			repeat (30) @(posedge clk);
			pulse(2);
		end
		chk(cpu_rst_o, 1'b0);
		await(0, 1'b1, 500);
		await(0, 1'b0, 200);
		rd(4'hB, 8'h00);
		// warm start again, then a power failure must clear it
		wr(4'hB, 8'h20);
		pulse(1);
		await(1, 1'b0, 5);
		repeat (40) @(posedge clk);
		chk(osc_en_o, 1'b0);
		pg <= 1'b0;
		@(posedge clk);
		pg <= 1'b1;
		await(0, 1'b1, 5);
		await(0, 1'b0, 200);
		rd(4'hB, 8'h00);
		// crystal-clocked watchdog; the rc source would fire within about 20 cycles
		wr(4'hD, 8'h1C);
		rd(4'hD, 8'h1C);
		pulse(2);
		repeat (300) @(posedge clk);
		chk(cpu_rst_o, 1'b0);
		await(0, 1'b1, 300);
		await(0, 1'b0, 200);
		wrap_up();
	end
endmodule
`default_nettype wire
